// >>> shared/gpfo_pkg.sv
// Purpose: Shared constants, register map and carriers for the galvo position front end
// Assumes: 16-bit signed digitizer words, angles in signed Q8.8 mechanical degrees
// Notes:   Each number lives here once; modules refer to it as gpfo_pkg::name
package gpfo_pkg;

  // ----------------------------------------------------------------
  // Geometry and fixed-point layout
  // ----------------------------------------------------------------
  localparam int NUM_AXES       = 2;
  localparam int FULL_SCALE_SH  = 15;   // Digitizer full scale is 2^15 counts
  localparam int POS_FRAC       = 8;    // Q8.8 degrees
  localparam int KTJ_UNIT       = 1000; // Ratio is entered in thousands
  localparam int OBS_SHIFT      = 24;   // Current-to-velocity integration step
  localparam int DAMP_SHIFT     = 12;   // Viscous leak step
  localparam int VEL_TO_POS     = 20;   // Velocity-to-position integration step
  localparam int CORR_SHIFT     = 6;    // Observer correction step on position

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 7;
  localparam int          GLOBAL_BIT  = 6;  // Set: global block
  localparam int          AXIS_BIT    = 5;  // Axis select inside axis block
  localparam logic [4:0]  AX_SCALE    = 5'h00;
  localparam logic [4:0]  AX_OFFSET   = 5'h04;
  localparam logic [4:0]  AX_POS_LIM  = 5'h08;
  localparam logic [4:0]  AX_NEG_LIM  = 5'h0C;
  localparam logic [4:0]  AX_KTJ      = 5'h10;
  localparam logic [4:0]  AX_VISC     = 5'h14;
  localparam logic [4:0]  AX_GAIN     = 5'h18;
  localparam logic [4:0]  AX_SPRING   = 5'h1C;
  localparam logic [6:0]  REG_CONTROL = 7'h40;
  localparam logic [6:0]  REG_STATUS  = 7'h44;
  localparam logic [6:0]  REG_MASK    = 7'h48;
  localparam logic [6:0]  REG_STATE   = 7'h4C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_PSEL_LSB = 0;  // Two bits: test point select
  localparam int CTRL_AXIS_BIT = 2;  // Probe axis
  localparam int ST_FAULT_LSB  = 0;  // One bit per axis
  localparam int ST_DONE_LSB   = 2;  // One bit per axis
  localparam int EV_W          = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] SCALE_RST   = 16'h1900;  // 25.0 degrees
  localparam logic [15:0] OFFSET_RST  = 16'h0000;
  localparam logic [15:0] POS_LIM_RST = 16'h1000;  // +16.0 degrees
  localparam logic [15:0] NEG_LIM_RST = 16'hF000;  // -16.0 degrees
  localparam logic [15:0] KTJ_RST     = 16'h02D4;
  localparam logic [15:0] VISC_RST    = 16'h000C;
  localparam logic [15:0] GAIN_RST    = 16'h0000;
  localparam logic [15:0] SPRING_RST  = 16'h0004;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ         = 125000;
  localparam int SHUTDOWN_MS     = 200;
  localparam int STARTUP_MS      = 3000;
  localparam int SHUTDOWN_CYCLES = SHUTDOWN_MS * CLK_KHZ;
  localparam int STARTUP_CYCLES  = STARTUP_MS * CLK_KHZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SRV_RUN, SRV_SHUTDOWN, SRV_STARTUP} gpfo_servo_e;

  typedef struct packed {
    logic [15:0] scale;
    logic [15:0] offset;
    logic [15:0] posLim;
    logic [15:0] negLim;
    logic [15:0] ktj;
    logic [15:0] visc;
    logic [15:0] gain;
    logic [15:0] spring;
  } gpfo_axis_cfg_s;

  typedef struct packed {
    logic [15:0] vel;
    logic [15:0] pos;
    logic [15:0] err;
  } gpfo_obs_out_s;

  function automatic logic [15:0] gpfo_sat16(input logic signed [47:0] v);
    if (v > 48'sh0000_0000_7FFF) return 16'h7FFF;
    if (v < -48'sh0000_0000_8000) return 16'h8000;
    return v[15:0];
  endfunction

  function automatic logic [31:0] gpfo_sat32(input logic signed [47:0] v);
    if (v > 48'sh0000_7FFF_FFFF) return 32'h7FFF_FFFF;
    if (v < -48'sh0000_8000_0000) return 32'h8000_0000;
    return v[31:0];
  endfunction

endpackage

// >>> test/gpfo_sensor_model.sv
// Purpose: Position sensor and drive coil stand-in for both axes
// Assumes: One servo sample every four core_clk cycles
// Notes:   Coil current is fixed; position follows rawSet
`timescale 1ns/1ps
module gpfo_sensor_model (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] rawSet,
  output logic             sampleStrobe,
  output logic [1:0][15:0] positionRaw,
  output logic [1:0][15:0] coilCurrent
);
  logic [1:0] phase_reg;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end
  // Spacing of four keeps above the three-cycle minimum
  assign sampleStrobe = (phase_reg == 2'h3);
  assign positionRaw  = {rawSet, rawSet};
  assign coilCurrent  = {16'h0100, 16'h0100};
endmodule

// >>> test/test_galvo_position_fault_and_observer.sv
// Purpose: Self-checking bench for gpfo_top
// Assumes: Shortened shutdown 16 and startup 32 cycles
// Notes:   Avalon master waits on waitrequest, bounded
`timescale 1ns/1ps
module test_galvo_position_fault_and_observer;
  logic                    core_clk = 1'b0;
  logic                    reset_n = 1'b0;
  logic [6:0]              avs_address = 7'h00;
  logic                    avs_read = 1'b0;
  logic                    avs_write = 1'b0;
  logic [31:0]             avs_writedata = 32'h0;
  logic [31:0]             avs_readdata;
  logic [31:0]             rd;
  logic                    avs_waitrequest;
  logic                    irq;
  logic                    sampleStrobe;
  logic [15:0]             rawSet = 16'h0000;
  logic [1:0][15:0]        positionRaw;
  logic [1:0][15:0]        coilCurrent;
  logic [1:0][15:0]        scaledPosition;
  logic [1:0][15:0]        hfVelocity;
  logic [15:0]             velProbe;
  logic [1:0]              driveEnable;
  logic [1:0]              servoReady;
  logic [15:0]             posProbe;
  logic [15:0]             errProbe;
  logic [15:0]             testPoint;
  int                      mismatches = 0;
  int                      samples_checked = 0;

  always #4 core_clk = ~core_clk;

  gpfo_sensor_model MODEL (.core_clk, .reset_n, .rawSet, .sampleStrobe, .positionRaw,
    .coilCurrent);
  gpfo_top #(.SHUTDOWN_CYCLES(32'h10), .STARTUP_CYCLES(32'h20)) DUT (.core_clk, .reset_n,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .irq, .sampleStrobe, .positionRaw, .coilCurrent, .scaledPosition, .hfVelocity,
    .driveEnable, .servoReady, .observedVelocityProbe(velProbe), .observedPositionProbe(posProbe),
    .observerErrorProbe(errProbe), .testPoint);

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) mismatches++;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [6:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Sample period is four cycles, plus settling
  task automatic strobes(input int n);
    repeat (n * 4 + 4) @(posedge core_clk);
  endtask

  task automatic waitReady();
    int n;
    for (n = 0; n < 300 && servoReady !== 2'b11; n++) @(posedge core_clk);
    chk({30'h0, servoReady}, 32'h3);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic tReset();
    rdchk(7'h00, 32'h1900);
    rdchk(7'h2C, 32'hF000);
    rdchk(7'h30, 32'h02D4);
    rdchk(7'h14, 32'h000C);
    rdchk(7'h50, 32'h0);
    waitReady();
    rdchk(7'h4C, 32'hF);
    rdchk(7'h44, 32'hC);
    bus(1'b1, 7'h44, 32'hF);
    rdchk(7'h44, 32'h0);
    $display("test reset done");
  endtask

  task automatic tScale();
    bus(1'b1, 7'h04, 32'h0100);
    rawSet <= 16'h4000;
    strobes(3);
    chk(scaledPosition[0], 32'h0D80);
    chk(scaledPosition[1], 32'h0C80);
    chk(errProbe, 32'h0);
    chk(posProbe, 32'h0D80);
    bus(1'b1, 7'h40, 32'h3);
    strobes(2);
    chk(testPoint, 32'h0D80);
    $display("test scale done");
  endtask

  task automatic tObserver();
    chk(hfVelocity[1], 32'h0);
    bus(1'b1, 7'h10, 32'h0);
    bus(1'b1, 7'h3C, 32'h20);
    bus(1'b1, 7'h40, 32'h4);
    rdchk(7'h40, 32'h4);
    // Spring pull now outweighs coil current on axis 1
    strobes(150);
    chk(hfVelocity[1], 32'hFFFF);
    chk(velProbe, 32'hFFFF);
    chk(testPoint, 32'hFFFF);
    bus(1'b1, 7'h40, 32'h5);
    strobes(2);
    chk(testPoint, 32'h0C80);
    bus(1'b1, 7'h18, 32'h1);
    bus(1'b1, 7'h40, 32'h2);
    rawSet <= 16'h2000;
    // First sample after the jump: error is new minus old position
    @(posedge core_clk iff sampleStrobe);
    repeat (4) @(posedge core_clk);
    chk(errProbe, 32'hF9C0);
    chk(testPoint, 32'hF9C0);
    $display("test observer done");
  endtask

  task automatic tFault(input logic [15:0] raw, input logic [31:0] expPos);
    bus(1'b1, 7'h48, 32'h1);
    rdchk(7'h48, 32'h1);
    rawSet <= raw;
    strobes(2);
    chk(scaledPosition[0], expPos);
    chk({30'h0, driveEnable}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rawSet <= 16'h0000;
    rdchk(7'h44, 32'h3);
    bus(1'b1, 7'h44, 32'hF);
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    waitReady();
    rdchk(7'h44, 32'hC);
    bus(1'b1, 7'h44, 32'hF);
    $display("test fault done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    tReset();
    tScale();
    tObserver();
    tFault(16'h8000, 32'hE800);
    tFault(16'h7FFF, 32'h19FF);
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    end_of_test();
  end
endmodule

// >>> verilog/gpfo_observer.sv
// Purpose: Rigid-body velocity observer for one axis, with current-integration bypass
// Assumes: sampleStrobe is one cycle per servo sample, inputs steady while it is high
// Notes:   Outputs come straight from the state flops
`timescale 1ns/1ps
module gpfo_observer (
  input  wire logic                    core_clk,
  input  wire logic                    reset_n,
  input  wire logic                    sampleStrobe,
  input  wire logic signed [15:0]      positionDeg,
  input  wire logic signed [15:0]      coilCurrent,
  input  wire gpfo_pkg::gpfo_axis_cfg_s cfg,
  output gpfo_pkg::gpfo_obs_out_s       obsOut
);

  typedef struct packed {
    logic [31:0] vel;
    logic [15:0] posEst;
    logic [15:0] err;
  } gpfo_obs_state_s;

  gpfo_obs_state_s     s;
  gpfo_obs_state_s     s_n;
  logic                gainOn;
  logic signed [47:0]  errW;
  logic signed [47:0]  springW;
  logic signed [47:0]  currW;
  logic signed [47:0]  driveW;
  logic signed [47:0]  dampW;
  logic signed [47:0]  corrW;
  logic signed [47:0]  velW;
  logic signed [47:0]  posW;

  // ----------------------------------------------------------------
  // Sample update
  // ----------------------------------------------------------------
  always_comb begin
    s_n     = s;
    gainOn  = (cfg.gain != 16'h0000);
    errW    = 48'(positionDeg) - 48'(signed'(s.posEst));
    // Holding current against the spring must not read as motion
    springW = (48'(signed'(cfg.spring)) * 48'(positionDeg)) >>> gpfo_pkg::POS_FRAC;
    currW   = 48'(coilCurrent) - springW;
    driveW  = (currW * 48'(signed'({1'b0, cfg.ktj})) * 48'(gpfo_pkg::KTJ_UNIT))
              >>> gpfo_pkg::OBS_SHIFT;
    dampW   = (48'(signed'({1'b0, cfg.visc})) * 48'(signed'(s.vel))) >>> gpfo_pkg::DAMP_SHIFT;
    corrW   = gainOn ? 48'(signed'({1'b0, cfg.gain})) * errW : 48'sh0;
    velW    = 48'(signed'(s.vel)) + driveW - dampW + corrW;
    posW    = 48'(signed'(s.posEst)) + (48'(signed'(s.vel)) >>> gpfo_pkg::VEL_TO_POS)
              + (corrW >>> gpfo_pkg::CORR_SHIFT);
    if (sampleStrobe) begin
      s_n.vel = gpfo_pkg::gpfo_sat32(velW);
      if (gainOn) begin
        s_n.posEst = gpfo_pkg::gpfo_sat16(posW);
        s_n.err    = gpfo_pkg::gpfo_sat16(errW);
      end else begin
        // Bypass: velocity is pure leaky current integration
        s_n.posEst = positionDeg;
        s_n.err    = 16'h0000;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= s_n;
    end
  end

  assign obsOut.vel = s.vel[31:16];
  assign obsOut.pos = s.posEst;
  assign obsOut.err = s.err;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cbObs @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  AST_BYPASS_TRACKS: assert property (
    sampleStrobe && cfg.gain == 16'h0000
    |=> obsOut.err == 16'h0000 && obsOut.pos == $past(positionDeg))
    else $error("Bypass did not track measured position");

  AST_CORR_ERROR: assert property (
    sampleStrobe && cfg.gain != 16'h0000
    |=> obsOut.err == gpfo_pkg::gpfo_sat16($past(errW)))
    else $error("Observer error not measured minus predicted");

  AST_ZERO_RATIO_HOLDS: assert property (
    sampleStrobe && cfg.gain == 16'h0000 && cfg.ktj == 16'h0000 && !s.vel[31]
    |=> signed'(s.vel) <= signed'($past(s.vel)))
    else $error("Velocity grew with zero ratio");

endmodule

// >>> verilog/gpfo_top.sv
// Purpose: Position scaling, window fault with restart, and velocity observers per axis
// Assumes: Digitizer words and sampleStrobe come from logic on core_clk
// Notes:   Registers over Avalon-MM, one wait state on every access
`timescale 1ns/1ps
module gpfo_top #(
  parameter logic [31:0] SHUTDOWN_CYCLES = 32'(gpfo_pkg::SHUTDOWN_CYCLES),
  parameter logic [31:0] STARTUP_CYCLES  = 32'(gpfo_pkg::STARTUP_CYCLES)
) (
  input  wire logic                                     core_clk,
  input  wire logic                                     reset_n,
  input  wire logic [gpfo_pkg::ADDR_W-1:0]              avs_address,
  input  wire logic                                     avs_read,
  input  wire logic                                     avs_write,
  input  wire logic [31:0]                              avs_writedata,
  output logic [31:0]                                   avs_readdata,
  output logic                                          avs_waitrequest,
  output logic                                          irq,
  input  wire logic                                     sampleStrobe,
  input  wire logic [gpfo_pkg::NUM_AXES-1:0][15:0]      positionRaw,
  input  wire logic [gpfo_pkg::NUM_AXES-1:0][15:0]      coilCurrent,
  output logic [gpfo_pkg::NUM_AXES-1:0][15:0]           scaledPosition,
  output logic [gpfo_pkg::NUM_AXES-1:0][15:0]           hfVelocity,
  output logic [gpfo_pkg::NUM_AXES-1:0]                 driveEnable,
  output logic [gpfo_pkg::NUM_AXES-1:0]                 servoReady,
  output logic [15:0]                                   observedVelocityProbe,
  output logic [15:0]                                   observedPositionProbe,
  output logic [15:0]                                   observerErrorProbe,
  output logic [15:0]                                   testPoint
);

  typedef struct packed {
    gpfo_pkg::gpfo_axis_cfg_s [gpfo_pkg::NUM_AXES-1:0] cfg;
    gpfo_pkg::gpfo_servo_e    [gpfo_pkg::NUM_AXES-1:0] srv;
    logic [gpfo_pkg::NUM_AXES-1:0][31:0]               cnt;
    logic [gpfo_pkg::NUM_AXES-1:0][15:0]               pos;
    logic [2:0]                                        ctrl;
    logic [gpfo_pkg::EV_W-1:0]                         status;
    logic [gpfo_pkg::EV_W-1:0]                         mask;
    logic                                              ack;
    logic [31:0]                                       rdata;
    logic                                              strobeD;
    logic [15:0]                                       velProbe;
    logic [15:0]                                       posProbe;
    logic [15:0]                                       errProbe;
    logic [15:0]                                       tp;
  } gpfo_top_s;

  gpfo_top_s                                    s;
  gpfo_top_s                                    s_n;
  gpfo_pkg::gpfo_obs_out_s [gpfo_pkg::NUM_AXES-1:0] obs;
  logic [gpfo_pkg::EV_W-1:0]                    evSet;
  logic [gpfo_pkg::EV_W-1:0]                    evClr;
  logic                                         req;
  logic                                         probeAxis;
  logic [15:0]                                  wdat;

  // ----------------------------------------------------------------
  // Register access helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] axisRead(input gpfo_pkg::gpfo_axis_cfg_s c,
                                           input logic [4:0] off);
    case (off)
      gpfo_pkg::AX_SCALE:   return c.scale;
      gpfo_pkg::AX_OFFSET:  return c.offset;
      gpfo_pkg::AX_POS_LIM: return c.posLim;
      gpfo_pkg::AX_NEG_LIM: return c.negLim;
      gpfo_pkg::AX_KTJ:     return c.ktj;
      gpfo_pkg::AX_VISC:    return c.visc;
      gpfo_pkg::AX_GAIN:    return c.gain;
      gpfo_pkg::AX_SPRING:  return c.spring;
      default:              return 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] scalePos(input logic [15:0] raw,
                                           input gpfo_pkg::gpfo_axis_cfg_s c);
    logic signed [47:0] prod;
    prod = (48'(signed'(raw)) * 48'(signed'({1'b0, c.scale}))) >>> gpfo_pkg::FULL_SCALE_SH;
    return gpfo_pkg::gpfo_sat16(prod + 48'(signed'(c.offset)));
  endfunction

  function automatic logic outOfWindow(input logic [15:0] p,
                                       input gpfo_pkg::gpfo_axis_cfg_s c);
    return (signed'(p) > signed'(c.posLim)) || (signed'(p) < signed'(c.negLim));
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_n       = s;
    req       = avs_read | avs_write;
    wdat      = avs_writedata[15:0];
    evSet     = '0;
    evClr     = '0;
    probeAxis = s.ctrl[gpfo_pkg::CTRL_AXIS_BIT];
    s_n.ack   = req & ~s.ack;
    s_n.strobeD = sampleStrobe;

    // Read data is latched in the wait cycle and held for the master
    if (req && !s.ack) begin
      s_n.rdata = 32'h0000_0000;
      if (!avs_address[gpfo_pkg::GLOBAL_BIT]) begin
        s_n.rdata[15:0] = axisRead(s.cfg[avs_address[gpfo_pkg::AXIS_BIT]], avs_address[4:0]);
      end else begin
        case (avs_address)
          gpfo_pkg::REG_CONTROL: s_n.rdata[2:0] = s.ctrl;
          gpfo_pkg::REG_STATUS:  s_n.rdata[gpfo_pkg::EV_W-1:0] = s.status;
          gpfo_pkg::REG_MASK:    s_n.rdata[gpfo_pkg::EV_W-1:0] = s.mask;
          gpfo_pkg::REG_STATE:   s_n.rdata[3:0] = {servoReady, driveEnable};
          default:               s_n.rdata = 32'h0000_0000;
        endcase
      end
    end

    if (avs_write && s.ack) begin
      if (!avs_address[gpfo_pkg::GLOBAL_BIT]) begin
        case (avs_address[4:0])
          gpfo_pkg::AX_SCALE:   s_n.cfg[avs_address[gpfo_pkg::AXIS_BIT]].scale  = wdat;
          gpfo_pkg::AX_OFFSET:  s_n.cfg[avs_address[gpfo_pkg::AXIS_BIT]].offset = wdat;
          gpfo_pkg::AX_POS_LIM: s_n.cfg[avs_address[gpfo_pkg::AXIS_BIT]].posLim = wdat;
          gpfo_pkg::AX_NEG_LIM: s_n.cfg[avs_address[gpfo_pkg::AXIS_BIT]].negLim = wdat;
          gpfo_pkg::AX_KTJ:     s_n.cfg[avs_address[gpfo_pkg::AXIS_BIT]].ktj    = wdat;
          gpfo_pkg::AX_VISC:    s_n.cfg[avs_address[gpfo_pkg::AXIS_BIT]].visc   = wdat;
          gpfo_pkg::AX_GAIN:    s_n.cfg[avs_address[gpfo_pkg::AXIS_BIT]].gain   = wdat;
          gpfo_pkg::AX_SPRING:  s_n.cfg[avs_address[gpfo_pkg::AXIS_BIT]].spring = wdat;
          default:              s_n.cfg = s.cfg;
        endcase
      end else begin
        case (avs_address)
          gpfo_pkg::REG_CONTROL: s_n.ctrl  = avs_writedata[2:0];
          gpfo_pkg::REG_STATUS:  evClr     = avs_writedata[gpfo_pkg::EV_W-1:0];
          gpfo_pkg::REG_MASK:    s_n.mask  = avs_writedata[gpfo_pkg::EV_W-1:0];
          default:               s_n.ctrl  = s.ctrl;
        endcase
      end
    end

    // Per-axis front end and fault sequencer
    for (int a = 0; a < gpfo_pkg::NUM_AXES; a++) begin
      if (sampleStrobe) begin
        s_n.pos[a] = scalePos(positionRaw[a], s.cfg[a]);
      end
      case (s.srv[a])
        gpfo_pkg::SRV_RUN, gpfo_pkg::SRV_STARTUP: begin
          // A breach during startup restarts the whole sequence
          if (s.strobeD && outOfWindow(s.pos[a], s.cfg[a])) begin
            s_n.srv[a] = gpfo_pkg::SRV_SHUTDOWN;
            s_n.cnt[a] = SHUTDOWN_CYCLES - 32'h0000_0001;
            evSet[gpfo_pkg::ST_FAULT_LSB + a] = 1'b1;
          end else if (s.srv[a] == gpfo_pkg::SRV_STARTUP) begin
            if (s.cnt[a] == 32'h0000_0000) begin
              s_n.srv[a] = gpfo_pkg::SRV_RUN;
              evSet[gpfo_pkg::ST_DONE_LSB + a] = 1'b1;
            end else begin
              s_n.cnt[a] = s.cnt[a] - 32'h0000_0001;
            end
          end
        end
        gpfo_pkg::SRV_SHUTDOWN: begin
          // Window is not judged while the axis is undriven
          if (s.cnt[a] == 32'h0000_0000) begin
            s_n.srv[a] = gpfo_pkg::SRV_STARTUP;
            s_n.cnt[a] = STARTUP_CYCLES - 32'h0000_0001;
          end else begin
            s_n.cnt[a] = s.cnt[a] - 32'h0000_0001;
          end
        end
        default: begin
          s_n.srv[a] = gpfo_pkg::SRV_SHUTDOWN;
          s_n.cnt[a] = SHUTDOWN_CYCLES - 32'h0000_0001;
        end
      endcase
    end

    // Set beats clear in the same cycle
    s_n.status = (s.status & ~evClr) | evSet;

    s_n.velProbe = obs[probeAxis].vel;
    s_n.posProbe = obs[probeAxis].pos;
    s_n.errProbe = obs[probeAxis].err;
    case (s.ctrl[gpfo_pkg::CTRL_PSEL_LSB +: 2])
      2'h0:    s_n.tp = obs[probeAxis].vel;
      2'h1:    s_n.tp = obs[probeAxis].pos;
      2'h2:    s_n.tp = obs[probeAxis].err;
      default: s_n.tp = s.pos[probeAxis];
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      for (int a = 0; a < gpfo_pkg::NUM_AXES; a++) begin
        s.cfg[a] <= '{gpfo_pkg::SCALE_RST, gpfo_pkg::OFFSET_RST, gpfo_pkg::POS_LIM_RST,
                      gpfo_pkg::NEG_LIM_RST, gpfo_pkg::KTJ_RST, gpfo_pkg::VISC_RST,
                      gpfo_pkg::GAIN_RST, gpfo_pkg::SPRING_RST};
        // Power-up goes through the same startup as a fault recovery
        s.srv[a] <= gpfo_pkg::SRV_SHUTDOWN;
        s.cnt[a] <= SHUTDOWN_CYCLES - 32'h0000_0001;
      end
    end else begin
      s <= s_n;
    end
  end

  // ----------------------------------------------------------------
  // Observers, one per axis
  // ----------------------------------------------------------------
  for (genvar g = 0; g < gpfo_pkg::NUM_AXES; g++) begin : gAxis
    gpfo_observer uObserver (
      .core_clk     (core_clk),
      .reset_n      (reset_n),
      .sampleStrobe (s.strobeD),
      .positionDeg  (s.pos[g]),
      .coilCurrent  (coilCurrent[g]),
      .cfg          (s.cfg[g]),
      .obsOut       (obs[g])
    );
    assign driveEnable[g] = (s.srv[g] != gpfo_pkg::SRV_SHUTDOWN);
    assign servoReady[g]  = (s.srv[g] == gpfo_pkg::SRV_RUN);
    assign hfVelocity[g]  = obs[g].vel;
  end

  assign avs_waitrequest       = req & ~s.ack;
  assign avs_readdata          = s.rdata;
  assign irq                   = |(s.status & s.mask);
  assign scaledPosition        = s.pos;
  assign observedVelocityProbe = s.velProbe;
  assign observedPositionProbe = s.posProbe;
  assign observerErrorProbe    = s.errProbe;
  assign testPoint             = s.tp;

  // ----------------------------------------------------------------
  // Checks (axis 0)
  // ----------------------------------------------------------------
  default clocking cbTop @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence seqTrip;
    s.strobeD && driveEnable[0] && outOfWindow(s.pos[0], s.cfg[0]);
  endsequence

  sequence seqHeldOff;
    !driveEnable[0] [*8];
  endsequence

  AST_SCALE: assert property (
    sampleStrobe |=> scaledPosition[0] == scalePos($past(positionRaw[0]), $past(s.cfg[0])))
    else $error("Scaled position wrong");

  AST_OFFSET: assert property (
    sampleStrobe && positionRaw[0] == 16'h0000 |=> scaledPosition[0] == $past(s.cfg[0].offset))
    else $error("Zero input does not give offset");

  AST_TRIP_STOPS_DRIVE: assert property (
    seqTrip |=> !driveEnable[0] && !servoReady[0])
    else $error("Window breach did not stop drive");

  AST_TRIP_FLAGS: assert property (
    seqTrip |=> s.status[gpfo_pkg::ST_FAULT_LSB])
    else $error("Fault not flagged");

  AST_HOLD_OFF: assert property (
    seqTrip |=> seqHeldOff)
    else $error("Drive returned too soon");

  AST_STARTUP_BEFORE_READY: assert property (
    $rose(servoReady[0]) |-> $past(driveEnable[0], 8) && !$past(servoReady[0]))
    else $error("Ready without startup phase");

  AST_SIGNED_LIMIT: assert property (
    s.strobeD && driveEnable[0] && signed'(s.pos[0]) < signed'(s.cfg[0].negLim)
    |=> !driveEnable[0])
    else $error("Negative limit not honoured");

  AST_PROBE: assert property (
    !probeAxis && $stable(probeAxis) |=> observerErrorProbe == $past(obs[0].err)
    && observedPositionProbe == $past(obs[0].pos))
    else $error("Probe does not follow observer");

  AST_BUS_ONE_WAIT: assert property (
    $rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("Bus access not answered in one cycle");

endmodule
